// file: tb/tb.sv
// Self-checking bench for the master and slave ends of the bus
`timescale 1ns/1ps
module tb;
  import uat_pkg::*;
  typedef struct {uat_op_e op; logic [1:0] off; logic [3:0] ln; logic [31:0] d;} uat_row_s;
  logic sys_clk, rst_n, req, req_nc, wr, lock_busy, busy, done, busy_nc, done_nc;
  logic wr_stb, ado_seen, adoh_seen, wr_stb_nc, got_stb, got_ado, got_adoh, got_nc, ado_nc, adoh_nc;
  logic [31:0] addr, wdata, rdata, rdata_nc, wr_addr, wr_data, rd_got, got_d, got_a;
  logic [5:0] am;
  logic [3:0] wr_lanes, got_ln;
  uat_op_e op;
  uat_rsp_e rsp, rsp_nc, rsp_got;
  int fail_count, n_tests, cyc;
  uat_row_s rows[7] = '{'{UAT_OP_QUAD, 2'h0, 4'hf, 32'h11223344},
    '{UAT_OP_TRI_0_2, 2'h0, 4'he, 32'ha1b2c3d4}, '{UAT_OP_TRI_1_3, 2'h1, 4'h7, 32'h55667788},
    '{UAT_OP_MID_1_2, 2'h1, 4'h6, 32'h99aabbcc}, '{UAT_OP_DBL, 2'h2, 4'h3, 32'h1357fdb9},
    '{UAT_OP_SINGLE, 2'h3, 4'h1, 32'h0000005a}, '{UAT_OP_SINGLE, 2'h2, 4'h2, 32'h0000a500}};
  uat_bus_if bus();
  uat_bus_if bus_nc();
  uat_master uat_master_inst(.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus.master), .req(req),
    .op(op), .wr(wr), .addr(addr), .am(am), .wdata(wdata), .busy(busy), .done(done),
    .rsp(rsp), .rdata(rdata));
  uat_slave #(.UAT_CAP(1'b1), .BASE(12'h0a5), .DEPTH(16)) uat_slave_inst(.sys_clk(sys_clk),
    .rst_n(rst_n), .bus(bus.slave), .lock_busy(lock_busy), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_lanes(wr_lanes), .wr_stb(wr_stb), .ado_seen(ado_seen),
    .adoh_seen(adoh_seen));
  // Second pair: slave without unaligned support
  uat_master uat_master_nc_inst(.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_nc.master),
    .req(req_nc), .op(op), .wr(wr), .addr(addr), .am(am), .wdata(wdata), .busy(busy_nc),
    .done(done_nc), .rsp(rsp_nc), .rdata(rdata_nc));
  uat_slave #(.UAT_CAP(1'b0), .BASE(12'h0a5), .DEPTH(16)) uat_slave_nc_inst(.sys_clk(sys_clk),
    .rst_n(rst_n), .bus(bus_nc.slave), .lock_busy(lock_busy), .wr_addr(), .wr_data(),
    .wr_lanes(), .wr_stb(wr_stb_nc), .ado_seen(ado_nc), .adoh_seen(adoh_nc));
  uat_bus_sva uat_bus_sva_inst(.sys_clk(sys_clk), .rst_n(rst_n), .addr(bus.addr), .am(bus.am),
    .lword_n(bus.lword_n), .as_n(bus.as_n), .ds0_n(bus.ds0_n), .ds1_n(bus.ds1_n),
    .write_n(bus.write_n), .m_doe(bus.m_doe), .s_doe(bus.s_doe), .dtack_n(bus.dtack_n),
    .berr_n(bus.berr_n), .retry_n(bus.retry_n), .dtack_oe(bus.dtack_oe),
    .berr_oe(bus.berr_oe), .retry_oe(bus.retry_oe));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk_val(string what, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_rsp(string what, uat_rsp_e e, uat_rsp_e g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", what, e, g);
    end
  endtask
  function automatic logic [31:0] lmask(logic [3:0] l);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  // Capture slave-side pulses between operations
  always @(posedge sys_clk) begin
    if (wr_stb === 1'b1) begin
      got_stb <= 1'b1;
      got_ln <= wr_lanes;
      got_d <= wr_data;
      got_a <= wr_addr;
    end
    if (ado_seen === 1'b1) got_ado <= 1'b1;
    if (adoh_seen === 1'b1) got_adoh <= 1'b1;
    if (wr_stb_nc === 1'b1 || bus_nc.dtack_n === 1'b0) got_nc <= 1'b1;
    if (ado_nc === 1'b1 || adoh_nc === 1'b1) got_nc <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic do_op(uat_op_e o, logic w, int word, logic [1:0] off, logic [31:0] d,
                       logic [5:0] m, logic nc);
    int n;
    n = 0;
    @(negedge sys_clk);
    op = o;
    wr = w;
    addr = {12'h0a5, 14'h0, 4'(word), off};
    wdata = d;
    am = m;
    got_stb = 1'b0;
    got_ado = 1'b0;
    got_adoh = 1'b0;
    req = !nc;
    req_nc = nc;
    while ((nc ? busy_nc : busy) !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    req = 1'b0;
    req_nc = 1'b0;
    while ((nc ? done_nc : done) !== 1'b1 && n < 600) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 600) begin
      fail_count++;
      $display("[FAIL] completion expected 1 seen 0");
    end
    rsp_got = nc ? rsp_nc : rsp;
    rd_got = nc ? rdata_nc : rdata;
  endtask
  initial begin
    rst_n = 1'b0;
    {req, req_nc, wr, lock_busy, got_stb, got_ado, got_adoh, got_nc} = 8'h00;
    {addr, wdata, got_d, got_a} = 128'h0;
    {am, got_ln} = 10'h009;
    op = UAT_OP_QUAD;
    {fail_count, n_tests, cyc} = 96'h0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      do_op(rows[i].op, 1'b1, i, rows[i].off, rows[i].d, 6'h09, 1'b0);
      chk_rsp("write response", UAT_RSP_OK, rsp_got);
      chk_val("write strobe", 32'h1, {31'h0, got_stb});
      chk_val("write lanes", {28'h0, rows[i].ln}, {28'h0, got_ln});
      chk_val("write data", rows[i].d & lmask(rows[i].ln), got_d & lmask(rows[i].ln));
      chk_val("write word", {addr[31:2], 2'h0}, {got_a[31:2], 2'h0});
      do_op(rows[i].op, 1'b0, i, rows[i].off, 32'h0, 6'h09, 1'b0);
      chk_rsp("read response", UAT_RSP_OK, rsp_got);
      chk_val("read data", rows[i].d & lmask(rows[i].ln), rd_got & lmask(rows[i].ln));
    end
    $display("lane table done");
    do_op(UAT_OP_SINGLE, 1'b1, 10, 2'h3, 32'h000000dd, 6'h09, 1'b0);
    do_op(UAT_OP_TRI_0_2, 1'b1, 10, 2'h0, 32'haabbcc00, 6'h09, 1'b0);
    do_op(UAT_OP_QUAD, 1'b0, 10, 2'h0, 32'h0, 6'h09, 1'b0);
    chk_val("descending parts", 32'haabbccdd, rd_got);
    $display("descending order done");
    do_op(UAT_OP_ADO, 1'b1, 0, 2'h0, 32'hdeadbeef, 6'h09, 1'b0);
    // Master finishes before the slave has seen the strobe rise
    repeat (8) @(negedge sys_clk);
    chk_val("address-only seen", 32'h1, {31'h0, got_ado});
    chk_val("address-only write", 32'h0, {31'h0, got_stb});
    do_op(UAT_OP_QUAD, 1'b0, 0, 2'h0, 32'h0, 6'h09, 1'b0);
    chk_val("data after address-only", 32'h11223344, rd_got);
    for (int k = 0; k < 3; k++) begin
      lock_busy = (k == 2);
      do_op(UAT_OP_ADOH, k[0], 5, 2'h0, 32'h0, 6'h3f, 1'b0);
      chk_rsp("handshake answer", (k == 2) ? UAT_RSP_RETRY : UAT_RSP_OK, rsp_got);
      chk_val("handshake seen", 32'h1, {31'h0, got_adoh});
    end
    lock_busy = 1'b0;
    $display("address-only done");
    do_op(UAT_OP_TRI_0_2, 1'b1, 3, 2'h0, 32'h01020304, 6'h09, 1'b1);
    chk_rsp("unsupported triple", UAT_RSP_NONE, rsp_got);
    do_op(UAT_OP_MID_1_2, 1'b0, 3, 2'h1, 32'h0, 6'h09, 1'b1);
    chk_rsp("unsupported middle", UAT_RSP_NONE, rsp_got);
    chk_val("unsupported acknowledge", 32'h0, {31'h0, got_nc});
    do_op(UAT_OP_QUAD, 1'b1, 3, 2'h0, 32'h01020304, 6'h09, 1'b1);
    chk_rsp("aligned on narrow slave", UAT_RSP_OK, rsp_got);
    $display("unsupported slave done");
    @(negedge sys_clk);
    {op, wr, addr, req} = {UAT_OP_QUAD, 1'b1, 32'h0a500004, 1'b1};
    repeat (5) @(negedge sys_clk);
    req = 1'b0;
    rst_n = 1'b0;
    #1;
    chk_val("strobes in reset", 32'h7, {29'h0, bus.as_n, bus.ds0_n, bus.ds1_n});
    chk_val("idle in reset", 32'h1, {30'h0, busy, bus.dtack_n});
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    do_op(UAT_OP_QUAD, 1'b0, 2, 2'h0, 32'h0, 6'h09, 1'b0);
    chk_rsp("read after reset", UAT_RSP_OK, rsp_got);
    $display("mid-cycle reset done");
    give_verdict();
  end
endmodule

// file: tb/uat_bus_sva.sv
// Concurrent checks on the bus joining the master and slave ends
`timescale 1ns/1ps
module uat_bus_sva
  import uat_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [UAT_AW-1:0] addr,
  input wire logic [UAT_AMW-1:0] am,
  input wire logic lword_n,
  input wire logic as_n,
  input wire logic ds0_n,
  input wire logic ds1_n,
  input wire logic write_n,
  input wire logic m_doe,
  input wire logic s_doe,
  input wire logic dtack_n,
  input wire logic berr_n,
  input wire logic retry_n,
  input wire logic dtack_oe,
  input wire logic berr_oe,
  input wire logic retry_oe
);
  import uat_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Strobes still high three cycles after the address strobe fell
  sequence ado_s;
    $fell(as_n) ##1 (ds0_n && ds1_n && !as_n)[*3];
  endsequence
  resp_drive_a: assert property ((dtack_oe == !dtack_n) && (berr_oe == !berr_n)
    && (retry_oe == !retry_n)) else $error("response enable differs from level");
  one_resp_a: assert property ($onehot0({~dtack_n, ~berr_n, ~retry_n}))
    else $error("more than one response low");
  resp_needs_ds_a: assert property (($fell(dtack_n) || $fell(berr_n) || $fell(retry_n))
    |-> !as_n && (!ds0_n || !ds1_n)) else $error("response without strobes");
  resp_hold_a: assert property (!dtack_n && (!ds0_n || !ds1_n) |=> !dtack_n)
    else $error("acknowledge dropped while strobes low");
  ds_in_as_a: assert property ((!ds0_n || !ds1_n) |-> !as_n)
    else $error("data strobe low outside address strobe");
  addr_stable_a: assert property (!as_n && $past(!as_n) |-> $stable({addr, am, lword_n}))
    else $error("address lines moved under address strobe");
  as_min_a: assert property ($fell(as_n) |-> (!as_n)[*4])
    else $error("address strobe too short");
  ado_end_a: assert property (ado_s |-> ##[1:8] as_n)
    else $error("address-only cycle not ended by master");
  ado_quiet_a: assert property (ado_s |-> (dtack_n && berr_n && retry_n)[*4])
    else $error("address-only cycle answered");
  read_drive_a: assert property (s_doe |-> write_n && !m_doe)
    else $error("slave drives data on write");
  resp_release_a: assert property ($rose(as_n) |-> ##[0:8] (dtack_n && berr_n && retry_n))
    else $error("response not released");
  ds_release_a: assert property ($fell(dtack_n) |-> ##[1:10] (ds0_n && ds1_n))
    else $error("strobes not released after acknowledge");
  cover property ($fell(dtack_n) && !write_n);
  cover property ($fell(dtack_n) && write_n);
  cover property ($fell(retry_n));
  cover property (ado_s);
endmodule

// file: verilog/uat_bus_if.sv
// Interface carrying the data transfer bus between master and slave ends
`timescale 1ns/1ps
interface uat_bus_if;
  import uat_pkg::*;
  logic [UAT_AW-1:0] addr;
  logic [UAT_AMW-1:0] am;
  logic iack_n;
  logic lword_n;
  logic as_n;
  logic ds0_n;
  logic ds1_n;
  logic write_n;
  logic [UAT_DW-1:0] m_dout;
  logic m_doe;
  logic [UAT_DW-1:0] s_dout;
  logic s_doe;
  logic dtack_n;
  logic berr_n;
  logic retry_n;
  logic dtack_oe;
  logic berr_oe;
  logic retry_oe;
  modport master (output addr, am, iack_n, lword_n, as_n, ds0_n, ds1_n, write_n,
                  m_dout, m_doe, input s_dout, s_doe, dtack_n, berr_n, retry_n);
  modport slave (input addr, am, iack_n, lword_n, as_n, ds0_n, ds1_n, write_n,
                 m_dout, m_doe, output s_dout, s_doe, dtack_n, berr_n, retry_n,
                 dtack_oe, berr_oe, retry_oe);
endinterface

// file: verilog/uat_lane_sel.sv
// Byte lane steering between a bus word and selected lanes
`timescale 1ns/1ps
module uat_lane_sel #(
  parameter int DW = 32
) (
  input wire logic [DW-1:0] new_word,
  input wire logic [DW-1:0] old_word,
  input wire logic [DW/8-1:0] lanes,
  output logic [DW-1:0] merged
);
  genvar g;
  generate
    for (g = 0; g < DW/8; g++) begin : g_lane
      assign merged[g*8 +: 8] = lanes[g] ? new_word[g*8 +: 8] : old_word[g*8 +: 8];
    end
  endgenerate
endmodule

// file: verilog/uat_master.sv
// Master end: issues aligned, unaligned and address-only cycles
`timescale 1ns/1ps
module uat_master
  import uat_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  uat_bus_if.master bus,
  input wire logic req,
  input wire uat_pkg::uat_op_e op,
  input wire logic wr,
  input wire logic [UAT_AW-1:0] addr,
  input wire logic [UAT_AMW-1:0] am,
  input wire logic [UAT_DW-1:0] wdata,
  output logic busy,
  output logic done,
  output uat_pkg::uat_rsp_e rsp,
  output logic [UAT_DW-1:0] rdata
);
  import uat_pkg::*;
  typedef enum logic [2:0] {
    UAT_M_IDLE = 3'h0,
    UAT_M_SETUP = 3'h1,
    UAT_M_ASL = 3'h2,
    UAT_M_DSL = 3'h3,
    UAT_M_HOLD = 3'h4,
    UAT_M_END = 3'h5
  } uat_mst_e;

  // Response pins synchronised by three stages
  logic [2:0] dt_s_ff, be_s_ff, rt_s_ff;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dt_s_ff <= 3'h7;
      be_s_ff <= 3'h7;
      rt_s_ff <= 3'h7;
    end else begin
      dt_s_ff <= {dt_s_ff[1:0], bus.dtack_n};
      be_s_ff <= {be_s_ff[1:0], bus.berr_n};
      rt_s_ff <= {rt_s_ff[1:0], bus.retry_n};
    end
  end
  logic dt_l, be_l, rt_l, any_l, all_h;
  assign dt_l = !dt_s_ff[1] && !dt_s_ff[2];
  assign be_l = !be_s_ff[1] && !be_s_ff[2];
  assign rt_l = !rt_s_ff[1] && !rt_s_ff[2];
  assign any_l = dt_l || be_l || rt_l;
  assign all_h = dt_s_ff[1] && dt_s_ff[2] && be_s_ff[1] && be_s_ff[2] && rt_s_ff[1] && rt_s_ff[2];

  uat_mst_e st_ff, nxt_st;
  logic [7:0] cnt_ff, nxt_cnt;
  logic as_ff, ds0_ff, ds1_ff, nxt_as, nxt_ds0, nxt_ds1;
  logic lw_ff, nxt_lw, wn_ff, nxt_wn, doe_ff, nxt_doe, busy_ff, nxt_busy, done_ff, nxt_done;
  logic [UAT_AW-1:0] a_ff, nxt_a;
  logic [UAT_AMW-1:0] am_ff, nxt_am;
  logic [UAT_DW-1:0] d_ff, nxt_d, rd_ff, nxt_rd;
  uat_op_e op_ff, nxt_op;
  uat_rsp_e rsp_ff, nxt_rsp;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_as = as_ff;
    nxt_ds0 = ds0_ff;
    nxt_ds1 = ds1_ff;
    nxt_lw = lw_ff;
    nxt_wn = wn_ff;
    nxt_doe = doe_ff;
    nxt_a = a_ff;
    nxt_am = am_ff;
    nxt_d = d_ff;
    nxt_rd = rd_ff;
    nxt_op = op_ff;
    nxt_rsp = rsp_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    case (st_ff)
      UAT_M_IDLE: begin
        if (req && all_h) begin
          // Lane coding: lword, a1 and a0 select triples and middle double
          nxt_a = addr;
          if (op == UAT_OP_QUAD) begin
            nxt_a[1:0] = 2'h0;
          end else if (op == UAT_OP_TRI_1_3) begin
            nxt_a[1:0] = 2'h1;
          end else if (op == UAT_OP_MID_1_2) begin
            nxt_a[1:0] = 2'h2;
          end else if (op == UAT_OP_TRI_0_2) begin
            nxt_a[1:0] = 2'h3;
          end
          nxt_lw = !((op == UAT_OP_QUAD) || (op == UAT_OP_TRI_0_2) ||
                     (op == UAT_OP_TRI_1_3) || (op == UAT_OP_MID_1_2));
          nxt_am = am;
          nxt_op = op;
          nxt_wn = !wr;
          nxt_d = wdata;
          nxt_busy = 1'b1;
          nxt_cnt = 8'h0;
          nxt_st = UAT_M_SETUP;
        end
      end
      UAT_M_SETUP: begin
        nxt_as = 1'b0;
        nxt_doe = !wn_ff && (op_ff != UAT_OP_ADO) && (op_ff != UAT_OP_ADOH);
        nxt_st = UAT_M_ASL;
      end
      UAT_M_ASL: begin
        if (op_ff == UAT_OP_ADO) begin
          nxt_cnt = 8'(UAT_ADO_HOLD_CYC);
          nxt_st = UAT_M_HOLD;
        end else begin
          nxt_ds0 = (op_ff == UAT_OP_SINGLE) && !a_ff[0];
          nxt_ds1 = (op_ff == UAT_OP_SINGLE) && a_ff[0];
          nxt_cnt = 8'(UAT_MST_TO_CYC);
          nxt_st = UAT_M_DSL;
        end
      end
      UAT_M_DSL: begin
        if (any_l || cnt_ff == 8'h0) begin
          nxt_rsp = dt_l ? UAT_RSP_OK : be_l ? UAT_RSP_ERR :
                    rt_l ? UAT_RSP_RETRY : UAT_RSP_NONE;
          nxt_rd = bus.s_dout;
          nxt_ds0 = 1'b1;
          nxt_ds1 = 1'b1;
          nxt_doe = 1'b0;
          nxt_as = 1'b1;
          nxt_st = UAT_M_END;
        end else begin
          nxt_cnt = cnt_ff - 8'h1;
        end
      end
      UAT_M_HOLD: begin
        if (cnt_ff == 8'h0) begin
          // Ends without waiting for any answer
          nxt_as = 1'b1;
          nxt_rsp = UAT_RSP_NONE;
          nxt_st = UAT_M_END;
        end else begin
          nxt_cnt = cnt_ff - 8'h1;
        end
      end
      UAT_M_END: begin
        if (all_h || op_ff == UAT_OP_ADO) begin
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
          nxt_st = UAT_M_IDLE;
        end
      end
      default: nxt_st = UAT_M_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= UAT_M_IDLE;
      cnt_ff <= 8'h0;
      as_ff <= 1'b1;
      ds0_ff <= 1'b1;
      ds1_ff <= 1'b1;
      lw_ff <= 1'b1;
      wn_ff <= 1'b1;
      doe_ff <= 1'b0;
      a_ff <= '0;
      am_ff <= '0;
      d_ff <= '0;
      rd_ff <= '0;
      op_ff <= UAT_OP_QUAD;
      rsp_ff <= UAT_RSP_NONE;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      as_ff <= nxt_as;
      ds0_ff <= nxt_ds0;
      ds1_ff <= nxt_ds1;
      lw_ff <= nxt_lw;
      wn_ff <= nxt_wn;
      doe_ff <= nxt_doe;
      a_ff <= nxt_a;
      am_ff <= nxt_am;
      d_ff <= nxt_d;
      rd_ff <= nxt_rd;
      op_ff <= nxt_op;
      rsp_ff <= nxt_rsp;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign bus.addr = a_ff;
  assign bus.am = am_ff;
  assign bus.iack_n = 1'b1;
  assign bus.lword_n = lw_ff;
  assign bus.as_n = as_ff;
  assign bus.ds0_n = ds0_ff;
  assign bus.ds1_n = ds1_ff;
  assign bus.write_n = wn_ff;
  assign bus.m_dout = d_ff;
  assign bus.m_doe = doe_ff;
  assign busy = busy_ff;
  assign done = done_ff;
  assign rsp = rsp_ff;
  assign rdata = rd_ff;
endmodule

// file: verilog/uat_pkg.sv
// Package of constants and types for the unaligned/address-only bus ends
package uat_pkg;
  localparam int UAT_DW = 32;
  localparam int UAT_AW = 32;
  localparam int UAT_AMW = 6;
  // Byte lane masks: lane 3 = D[31:24] ... lane 0 = D[7:0]
  localparam logic [3:0] UAT_LN_QUAD = 4'hf;
  localparam logic [3:0] UAT_LN_TRI_LO = 4'h7;
  localparam logic [3:0] UAT_LN_TRI_HI = 4'he;
  localparam logic [3:0] UAT_LN_MID = 4'h6;
  localparam logic [3:0] UAT_LN_DBL = 4'h3;
  localparam logic [3:0] UAT_LN_HI_BYTE = 4'h2;
  localparam logic [3:0] UAT_LN_LO_BYTE = 4'h1;
  localparam logic [3:0] UAT_LN_NONE = 4'h0;
  // Address-only hold time and derived cycles at 40 MHz
  localparam int UAT_CLK_NS = 25;
  localparam int UAT_ADO_HOLD_NS = 100;
  localparam int UAT_ADO_HOLD_CYC = (UAT_ADO_HOLD_NS + UAT_CLK_NS - 1) / UAT_CLK_NS;
  localparam int UAT_SLV_DLY_CYC = 2;
  localparam int UAT_MST_TO_CYC = 255;
  typedef enum logic [2:0] {
    UAT_OP_QUAD = 3'h0,
    UAT_OP_TRI_0_2 = 3'h1,
    UAT_OP_TRI_1_3 = 3'h2,
    UAT_OP_MID_1_2 = 3'h3,
    UAT_OP_DBL = 3'h4,
    UAT_OP_SINGLE = 3'h5,
    UAT_OP_ADO = 3'h6,
    UAT_OP_ADOH = 3'h7
  } uat_op_e;
  typedef enum logic [1:0] {
    UAT_RSP_OK = 2'h0,
    UAT_RSP_ERR = 2'h1,
    UAT_RSP_RETRY = 2'h2,
    UAT_RSP_NONE = 2'h3
  } uat_rsp_e;
  // Strobe/lword/a1/a0 coding: ds1_n, ds0_n, a01, lword_n -> lanes
  function automatic logic [3:0] uat_lanes(input logic ds1_n, input logic ds0_n,
                                           input logic a01, input logic lword_n,
                                           input logic a00);
    logic [3:0] l;
    l = UAT_LN_NONE;
    if (!ds1_n && !ds0_n) begin
      if (!lword_n && !a01 && !a00) begin
        l = UAT_LN_QUAD;
      end else if (!lword_n && !a01 && a00) begin
        l = UAT_LN_TRI_LO;
      end else if (!lword_n && a01 && !a00) begin
        l = UAT_LN_MID;
      end else if (lword_n) begin
        l = UAT_LN_DBL;
      end else begin
        l = UAT_LN_TRI_HI;
      end
    end else if (!ds1_n || !ds0_n) begin
      l = ds0_n ? UAT_LN_HI_BYTE : UAT_LN_LO_BYTE;
    end
    return l;
  endfunction
endpackage

// file: verilog/uat_slave.sv
// Slave end: decodes aligned, unaligned and address-only cycles
// Summary of operation
// - Quad all lanes, bytes by parity, double low
// - Triple cycles use low or upper 24 lines
// - Middle double-byte uses lanes one and two
// - Master byte order free; slave ignores it
// - Unaligned needs full 32-bit path
// - Support both triples and middle double
// - Unaligned capability recommended for 32-bit ends
// - Non-capable slave never acknowledges unaligned
// - Address-only: address valid, strobes held high
// - Master ends address-only alone after hold
// - Address-only needs no slave answer
// - Handshake variant also lowers data strobes
// - Handshake variant answered by ack/error/retry
// - Write level free in handshake variant
// - Slaves tolerate address-only without side effects
`timescale 1ns/1ps
module uat_slave
  import uat_pkg::*;
#(
  parameter logic UAT_CAP = 1'b1,
  parameter logic [UAT_AW-1:20] BASE = 12'h000,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  uat_bus_if.slave bus,
  input wire logic lock_busy,
  output logic [UAT_AW-1:0] wr_addr,
  output logic [UAT_DW-1:0] wr_data,
  output logic [3:0] wr_lanes,
  output logic wr_stb,
  output logic ado_seen,
  output logic adoh_seen
);
  import uat_pkg::*;
  localparam int IW = $clog2(DEPTH);

  typedef enum logic [2:0] {
    UAT_S_IDLE = 3'h0,
    UAT_S_WAIT = 3'h1,
    UAT_S_XFER = 3'h2,
    UAT_S_RESP = 3'h3,
    UAT_S_DONE = 3'h4
  } uat_sst_e;

  // Three-stage input synchronisers
  logic [2:0] as_s_ff, ds0_s_ff, ds1_s_ff;
  logic as_q_ff, ds0_q_ff, ds1_q_ff;
  logic nxt_as_q, nxt_ds0_q, nxt_ds1_q;
  always_comb begin
    nxt_as_q = (as_s_ff[1] == as_s_ff[2]) ? as_s_ff[2] : as_q_ff;
    nxt_ds0_q = (ds0_s_ff[1] == ds0_s_ff[2]) ? ds0_s_ff[2] : ds0_q_ff;
    nxt_ds1_q = (ds1_s_ff[1] == ds1_s_ff[2]) ? ds1_s_ff[2] : ds1_q_ff;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      as_s_ff <= 3'h7;
      ds0_s_ff <= 3'h7;
      ds1_s_ff <= 3'h7;
      as_q_ff <= 1'b1;
      ds0_q_ff <= 1'b1;
      ds1_q_ff <= 1'b1;
    end else begin
      as_s_ff <= {as_s_ff[1:0], bus.as_n};
      ds0_s_ff <= {ds0_s_ff[1:0], bus.ds0_n};
      ds1_s_ff <= {ds1_s_ff[1:0], bus.ds1_n};
      as_q_ff <= nxt_as_q;
      ds0_q_ff <= nxt_ds0_q;
      ds1_q_ff <= nxt_ds1_q;
    end
  end

  logic [UAT_DW-1:0] mem_ff [DEPTH];
  logic [UAT_DW-1:0] cur_word, merged;
  logic [3:0] lanes;
  logic [IW-1:0] idx;
  logic hit, unal, adoh_req;
  assign idx = bus.addr[IW+1:2];
  assign hit = (bus.addr[UAT_AW-1:20] == BASE) && bus.iack_n;
  assign cur_word = mem_ff[idx];
  // Lanes decoded from stable strobes; any order of parts accepted
  assign lanes = uat_lanes(ds1_q_ff, ds0_q_ff, bus.addr[1], bus.lword_n, bus.addr[0]);
  // Triples and middle double are the unaligned cycles
  assign unal = (lanes == UAT_LN_TRI_LO) || (lanes == UAT_LN_TRI_HI) || (lanes == UAT_LN_MID);
  // Strobes low with no data mode bit: handshake address-only on am 0x3f
  assign adoh_req = (bus.am == 6'h3f);

  uat_lane_sel #(.DW(UAT_DW)) u_sel (
    .new_word(bus.m_dout),
    .old_word(cur_word),
    .lanes(lanes),
    .merged(merged)
  );

  uat_sst_e st_ff, nxt_st;
  logic [1:0] dly_ff, nxt_dly;
  logic dtack_ff, berr_ff, retry_ff, nxt_dtack, nxt_berr, nxt_retry;
  logic sdoe_ff, nxt_sdoe;
  logic [UAT_DW-1:0] sdout_ff, nxt_sdout;
  logic wstb_ff, nxt_wstb, ado_ff, nxt_ado, adoh_ff, nxt_adoh;
  logic [UAT_AW-1:0] waddr_ff, nxt_waddr;
  logic [UAT_DW-1:0] wdata_ff, nxt_wdata;
  logic [3:0] wlanes_ff, nxt_wlanes;

  always_comb begin
    nxt_st = st_ff;
    nxt_dly = dly_ff;
    nxt_dtack = dtack_ff;
    nxt_berr = berr_ff;
    nxt_retry = retry_ff;
    nxt_sdoe = sdoe_ff;
    nxt_sdout = sdout_ff;
    nxt_wstb = 1'b0;
    nxt_ado = 1'b0;
    nxt_adoh = 1'b0;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wlanes = wlanes_ff;
    case (st_ff)
      UAT_S_IDLE: begin
        if (!as_q_ff && hit) begin
          nxt_st = UAT_S_WAIT;
        end
      end
      UAT_S_WAIT: begin
        if (as_q_ff) begin
          // Address strobe rose with strobes high: no answer, no effect
          nxt_ado = 1'b1;
          nxt_st = UAT_S_IDLE;
        end else if (!ds0_q_ff || !ds1_q_ff) begin
          nxt_dly = 2'(UAT_SLV_DLY_CYC);
          nxt_st = UAT_S_XFER;
        end
      end
      UAT_S_XFER: begin
        if (dly_ff != 2'h0) begin
          nxt_dly = dly_ff - 2'h1;
        end else if (adoh_req) begin
          // Answer regardless of write level, no data moved
          nxt_adoh = 1'b1;
          nxt_retry = lock_busy;
          nxt_dtack = !lock_busy;
          nxt_st = UAT_S_RESP;
        end else if (unal && !UAT_CAP) begin
          nxt_st = UAT_S_DONE;
        end else if (lanes == UAT_LN_TRI_HI && bus.addr[0] == 1'b0 && bus.lword_n) begin
          nxt_berr = 1'b1;
          nxt_st = UAT_S_RESP;
        end else begin
          // Write merges only the selected lanes, read drives the whole word, both set with acknowledge
          if (!bus.write_n) begin
            nxt_wstb = 1'b1;
            nxt_waddr = bus.addr;
            nxt_wdata = merged;
            nxt_wlanes = lanes;
          end else begin
            nxt_sdout = cur_word;
            nxt_sdoe = 1'b1;
          end
          nxt_dtack = 1'b1;
          nxt_st = UAT_S_RESP;
        end
      end
      UAT_S_RESP: begin
        if (ds0_q_ff && ds1_q_ff) begin
          nxt_dtack = 1'b0;
          nxt_berr = 1'b0;
          nxt_retry = 1'b0;
          nxt_sdoe = 1'b0;
          nxt_st = UAT_S_DONE;
        end
      end
      UAT_S_DONE: begin
        if (as_q_ff) begin
          nxt_st = UAT_S_IDLE;
        end
      end
      default: nxt_st = UAT_S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= UAT_S_IDLE;
      dly_ff <= 2'h0;
      dtack_ff <= 1'b0;
      berr_ff <= 1'b0;
      retry_ff <= 1'b0;
      sdoe_ff <= 1'b0;
      sdout_ff <= '0;
      wstb_ff <= 1'b0;
      ado_ff <= 1'b0;
      adoh_ff <= 1'b0;
      waddr_ff <= '0;
      wdata_ff <= '0;
      wlanes_ff <= 4'h0;
    end else begin
      st_ff <= nxt_st;
      dly_ff <= nxt_dly;
      dtack_ff <= nxt_dtack;
      berr_ff <= nxt_berr;
      retry_ff <= nxt_retry;
      sdoe_ff <= nxt_sdoe;
      sdout_ff <= nxt_sdout;
      wstb_ff <= nxt_wstb;
      ado_ff <= nxt_ado;
      adoh_ff <= nxt_adoh;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wlanes_ff <= nxt_wlanes;
    end
  end

  // Storage updated with the merged word, selected lanes only
  always_ff @(posedge sys_clk) begin
    if (wstb_ff) begin
      mem_ff[waddr_ff[IW+1:2]] <= wdata_ff;
    end
  end

  assign bus.dtack_n = !dtack_ff;
  assign bus.berr_n = !berr_ff;
  assign bus.retry_n = !retry_ff;
  assign bus.dtack_oe = dtack_ff;
  assign bus.berr_oe = berr_ff;
  assign bus.retry_oe = retry_ff;
  assign bus.s_dout = sdout_ff;
  assign bus.s_doe = sdoe_ff;
  assign wr_addr = waddr_ff;
  assign wr_data = wdata_ff;
  assign wr_lanes = wlanes_ff;
  assign wr_stb = wstb_ff;
  assign ado_seen = ado_ff;
  assign adoh_seen = adoh_ff;
endmodule
